// [core/word_decode_pointer_unit.sv]
`timescale 1ns/1ps
// Summary of operation
// - Four two-word instructions, second word marked
// - Top nibble all ones alone decodes NOP
// - In-sequence second word supplies twelve-bit operand
// - Orphan second word after skip: no effect
// - Pointer modification carries across whole pair
// - Pointer modification never touches status flags
// - Plus-working window addresses pointer plus working
// - Indirect read of virtual window returns 00h
// - Indirect write to virtual window discarded
// - Window write to pointer stores unmodified value
// - Pointer bytes directly readable and writable
// - Other registers fully reachable through windows
// - Extended enable adds indexed access-bank mode
// - Extended mode keeps memory map unchanged
// - Extended mode keeps other addressing unchanged
// - Extended mode leaves pointers zero, one unchanged
// - Extended: file at most 5Fh offsets pointer two
// - Jump target loads counter bits 20:1, bit0 zero
module word_decode_pointer_unit
   import word_decode_pkg::*;
(
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RSTN,
   // Instruction word stream
   input wire logic [WORD_W-1:0] I_WORD,
   input wire logic I_WORD_VALID,
   input wire logic I_WORD_SKIP,
   // Configuration
   input wire logic I_EXT_ENABLE,
   // Data access request
   input wire access_type I_ACC,
   input wire logic [DATA_W-1:0] I_WREG,
   // Data memory read return
   input wire logic [DATA_W-1:0] I_MEM_RDATA,
   // Decode results
   output dec_type O_DEC,
   output logic [PC_W-1:0] O_PC_TARGET,
   output logic O_PC_LOAD,
   // Data memory request
   output mem_type O_MEM,
   // Data access answer
   output logic O_ACC_DONE,
   output logic [DATA_W-1:0] O_ACC_RDATA,
   output logic O_ACC_BUSY
);

   typedef enum {DEC_FIRST, DEC_SECOND} dec_state_type;
   typedef enum {ACC_IDLE, ACC_ISSUE, ACC_WAIT} acc_state_type;

   // Decoder state
   dec_state_type dec_state_reg, dec_state_next;
   logic [WORD_W-1:0] first_reg, first_next;
   dec_type dec_reg, dec_next;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic pc_load_reg, pc_load_next;
   logic ld_req;
   logic [1:0] ld_sel;
   logic [ADDR_W-1:0] ld_val;

   // Pointer and access state
   acc_state_type acc_state_reg, acc_state_next;
   logic [ADDR_W-1:0] ptr_reg [NUM_PTR];
   logic [ADDR_W-1:0] ptr_next [NUM_PTR];
   mem_type mem_reg, mem_next;
   logic done_reg, done_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic busy_reg, busy_next;

   // Classify a word as the first word of a pair or a single word
   function automatic kind_type first_kind(input logic [WORD_W-1:0] w);
      kind_type k;
      k = KIND_SINGLE;
      if (w[WORD_W-1:MARK_LSB] == MOVE_OPC) begin
         k = KIND_MOVE;
      end else if (w[WORD_W-1:OPC8_LSB] == JUMP_OPC) begin
         k = KIND_JUMP;
      end else if (w[WORD_W-1:CALL_LSB] == CALL_OPC) begin
         k = KIND_CALL;
      end else if (w[WORD_W-1:OPC8_LSB] == LOAD_OPC &&
                   w[LOAD_PAD_MSB:LOAD_PAD_LSB] == LOAD_PAD) begin
         k = KIND_LOAD;
      end
      return k;
   endfunction : first_kind

   // Locate an address among the virtual windows and pointer bytes
   function automatic win_hit_type decode_win(input logic [ADDR_W-1:0] a);
      win_hit_type h;
      logic [ADDR_W-1:0] d;
      h = '0;
      for (int n = 0; n < NUM_PTR; n++) begin
         d = WIN_TOP - ADDR_W'(n * WIN_STRIDE) - a;
         if (d <= OFS_POINTER_PLUS_WORKING_ACCESS) begin
            h.hit_virtual = 1'b1;
            h.sel = 2'(n);
            h.kind = win_kind_type'(d[2:0]);
         end
         if (d == OFS_HIGH) begin
            h.hit_high = 1'b1;
            h.sel = 2'(n);
         end
         if (d == OFS_LOW) begin
            h.hit_low = 1'b1;
            h.sel = 2'(n);
         end
      end
      return h;
   endfunction : decode_win

   // Instruction decoder next state
   always_comb begin
      dec_state_next = dec_state_reg;
      first_next = first_reg;
      dec_next = '0;
      pc_next = pc_reg;
      pc_load_next = 1'b0;
      ld_req = 1'b0;
      ld_sel = '0;
      ld_val = '0;
      if (I_WORD_VALID) begin
         if (I_WORD_SKIP) begin
            // Skipped word never arms the second-word path
            dec_state_next = DEC_FIRST;
         end else if (dec_state_reg == DEC_SECOND &&
                      I_WORD[WORD_W-1:MARK_LSB] == SECOND_MARK) begin
            dec_state_next = DEC_FIRST;
            dec_next.valid = 1'b1;
            dec_next.kind = first_kind(first_reg);
            dec_next.literal = I_WORD[LIT_W-1:0];
            case (first_kind(first_reg))
               KIND_CALL, KIND_JUMP: begin
                  pc_next = {I_WORD[LIT_W-1:0], first_reg[JUMP_LO_MSB:0],
                             PC_LSB_VALUE};
                  pc_load_next = 1'b1;
               end
               KIND_MOVE: begin
                  dec_next.src = first_reg[LIT_W-1:0];
                  dec_next.dst = I_WORD[LIT_W-1:0];
               end
               KIND_LOAD: begin
                  ld_req = 1'b1;
                  ld_sel = first_reg[LOAD_SEL_MSB:LOAD_SEL_LSB];
                  ld_val = {first_reg[LOAD_HI_MSB:0], I_WORD[LOAD_LO_MSB:0]};
               end
               default: begin
                  dec_next.kind = KIND_NOP;
               end
            endcase
         end else if (I_WORD[WORD_W-1:MARK_LSB] == SECOND_MARK) begin
            // Orphan second word: reported, but nothing else moves
            dec_state_next = DEC_FIRST;
            dec_next.valid = 1'b1;
            dec_next.kind = KIND_NOP;
         end else if (first_kind(I_WORD) != KIND_SINGLE) begin
            // Completion waits for the second fetch
            first_next = I_WORD;
            dec_state_next = DEC_SECOND;
         end else begin
            dec_state_next = DEC_FIRST;
            dec_next.valid = 1'b1;
            dec_next.kind = KIND_SINGLE;
            dec_next.literal = I_WORD[LIT_W-1:0];
         end
      end
   end

   // Instruction decoder registers
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RSTN) begin
         dec_state_reg <= DEC_FIRST;
         first_reg <= '0;
         dec_reg <= '0;
         pc_reg <= '0;
         pc_load_reg <= 1'b0;
      end else begin
         dec_state_reg <= dec_state_next;
         first_reg <= first_next;
         dec_reg <= dec_next;
         pc_reg <= pc_next;
         pc_load_reg <= pc_load_next;
      end
   end

   // Pointer pairs and data access next state
   always_comb begin
      logic [ADDR_W-1:0] eff;
      logic [ADDR_W-1:0] tgt;
      logic [ADDR_W-1:0] p;
      logic [ADDR_W-1:0] newp;
      logic indirect;
      win_hit_type hit;
      win_hit_type th;
      eff = '0;
      tgt = '0;
      p = '0;
      newp = '0;
      indirect = 1'b0;
      hit = '0;
      th = '0;
      acc_state_next = acc_state_reg;
      ptr_next = ptr_reg;
      mem_next = mem_reg;
      mem_next.req = 1'b0;
      done_next = 1'b0;
      rdata_next = rdata_reg;
      busy_next = busy_reg;
      case (acc_state_reg)
         ACC_IDLE: begin
            if (I_ACC.valid) begin
               // Indexed mode only for low access-bank files
               if (!I_ACC.bank_sel && I_EXT_ENABLE && I_ACC.file <= OFFSET_MAX) begin
                  eff = ptr_reg[IDX_TWO] + ADDR_W'(I_ACC.file);
               end else if (!I_ACC.bank_sel) begin
                  eff = (I_ACC.file < ACCESS_SPLIT) ? {LOW_BANK, I_ACC.file} :
                        {HIGH_BANK, I_ACC.file};
               end else begin
                  eff = {I_ACC.bank, I_ACC.file};
               end
               hit = decode_win(eff);
               tgt = eff;
               th = hit;
               if (hit.hit_virtual) begin
                  // Same window logic for every pointer in both modes
                  indirect = 1'b1;
                  p = ptr_reg[hit.sel];
                  newp = p;
                  tgt = p; // Post-step windows reach the cell before the step
                  case (hit.kind)
                     WIN_INC: newp = p + PTR_STEP;
                     WIN_DEC: newp = p - PTR_STEP;
                     WIN_PRE: begin
                        newp = p + PTR_STEP;
                        tgt = newp;
                     end
                     WIN_POINTER_PLUS_WORKING_ACCESS: begin
                        tgt = p + {{HIGH_W{I_WREG[DATA_W-1]}}, I_WREG};
                     end
                     default: tgt = p;
                  endcase
                  th = decode_win(tgt);
               end
               if (indirect && th.hit_virtual) begin
                  // Window through window: read zero, write dropped
                  rdata_next = VIRT_READ_VALUE;
                  done_next = 1'b1;
               end else begin
                  if (indirect) begin
                     // Full 12-bit step; no status flag path exists here
                     ptr_next[hit.sel] = newp;
                  end
                  if (th.hit_low || th.hit_high) begin
                     done_next = 1'b1;
                     if (I_ACC.write && th.hit_low) begin
                        // Stored value cancels any pending step of this pair
                        ptr_next[th.sel] = ptr_reg[th.sel];
                        ptr_next[th.sel][DATA_W-1:0] = I_ACC.wdata;
                     end else if (I_ACC.write) begin
                        ptr_next[th.sel] = ptr_reg[th.sel];
                        ptr_next[th.sel][ADDR_W-1:DATA_W] =
                           I_ACC.wdata[HIGH_W-1:0];
                     end else if (th.hit_low) begin
                        rdata_next = ptr_reg[th.sel][DATA_W-1:0];
                     end else begin
                        rdata_next = DATA_W'(ptr_reg[th.sel][ADDR_W-1:DATA_W]);
                     end
                  end else begin
                     // Any other register or memory cell, full effect
                     mem_next.req = 1'b1;
                     mem_next.write = I_ACC.write;
                     mem_next.addr = tgt;
                     mem_next.wdata = I_ACC.wdata;
                     busy_next = 1'b1;
                     acc_state_next = ACC_ISSUE;
                  end
               end
            end
         end
         ACC_ISSUE: begin
            acc_state_next = ACC_WAIT;
         end
         ACC_WAIT: begin
            // Memory answers one cycle after the request
            if (!mem_reg.write) begin
               rdata_next = I_MEM_RDATA;
            end
            done_next = 1'b1;
            busy_next = 1'b0;
            acc_state_next = ACC_IDLE;
         end
         default: begin
            acc_state_next = ACC_IDLE;
            busy_next = 1'b0;
         end
      endcase
      // Literal load wins over a same-cycle access write
      if (ld_req && ld_sel < 2'(NUM_PTR)) begin
         ptr_next[ld_sel] = ld_val;
      end
   end

   // Pointer and access registers
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RSTN) begin
         acc_state_reg <= ACC_IDLE;
         for (int n = 0; n < NUM_PTR; n++) begin
            ptr_reg[n] <= PTR_RESET;
         end
         mem_reg <= '0;
         done_reg <= 1'b0;
         rdata_reg <= '0;
         busy_reg <= 1'b0;
      end else begin
         acc_state_reg <= acc_state_next;
         ptr_reg <= ptr_next;
         mem_reg <= mem_next;
         done_reg <= done_next;
         rdata_reg <= rdata_next;
         busy_reg <= busy_next;
      end
   end

   // Outputs straight from flip-flops
   assign O_DEC = dec_reg;
   assign O_PC_TARGET = pc_reg;
   assign O_PC_LOAD = pc_load_reg;
   assign O_MEM = mem_reg;
   assign O_ACC_DONE = done_reg;
   assign O_ACC_RDATA = rdata_reg;
   assign O_ACC_BUSY = busy_reg;

endmodule : word_decode_pointer_unit

// [core/word_decode_pkg.sv]
package word_decode_pkg;
   // Widths
   localparam int WORD_W = 16;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int LIT_W = 12;
   localparam int PC_W = 21;
   localparam int NUM_PTR = 3;
   localparam int HIGH_W = ADDR_W - DATA_W;

   // Instruction word field positions
   localparam int MARK_LSB = 12;
   localparam int OPC8_LSB = 8;
   localparam int CALL_LSB = 9;
   localparam int LOAD_PAD_MSB = 7;
   localparam int LOAD_PAD_LSB = 6;
   localparam int LOAD_SEL_MSB = 5;
   localparam int LOAD_SEL_LSB = 4;
   localparam int LOAD_HI_MSB = 3;
   localparam int LOAD_LO_MSB = 7;
   localparam int JUMP_LO_MSB = 7;

   // Opcode patterns
   localparam logic [3:0] SECOND_MARK = 4'hF;
   localparam logic [3:0] MOVE_OPC = 4'hC;
   localparam logic [7:0] JUMP_OPC = 8'hEF;
   localparam logic [6:0] CALL_OPC = 7'h76;
   localparam logic [7:0] LOAD_OPC = 8'hEE;
   localparam logic [1:0] LOAD_PAD = 2'h0;
   localparam logic PC_LSB_VALUE = 1'b0;

   // Data space layout
   localparam logic [7:0] OFFSET_MAX = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] LOW_BANK = 4'h0;
   localparam logic [3:0] HIGH_BANK = 4'hF;
   localparam logic [ADDR_W-1:0] WIN_TOP = 12'hFEF;
   localparam int WIN_STRIDE = 8;
   localparam logic [ADDR_W-1:0] OFS_POINTER_PLUS_WORKING_ACCESS = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_HIGH = 12'h005;
   localparam logic [ADDR_W-1:0] OFS_LOW = 12'h006;
   localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;
   localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
   localparam logic [DATA_W-1:0] VIRT_READ_VALUE = 8'h00;
   localparam logic [1:0] IDX_TWO = 2'h2;

   // Decoded instruction kinds
   typedef enum logic [2:0] {
      KIND_NONE, KIND_SINGLE, KIND_NOP, KIND_CALL, KIND_JUMP, KIND_MOVE, KIND_LOAD
   } kind_type;

   // Virtual window access kinds, in window offset order
   typedef enum logic [2:0] {
      WIN_PLAIN, WIN_INC, WIN_DEC, WIN_PRE, WIN_POINTER_PLUS_WORKING_ACCESS
   } win_kind_type;

   typedef struct packed {
      logic valid;
      kind_type kind;
      logic [LIT_W-1:0] literal;
      logic [ADDR_W-1:0] src;
      logic [ADDR_W-1:0] dst;
   } dec_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic bank_sel;
      logic [HIGH_W-1:0] bank;
      logic [DATA_W-1:0] file;
      logic [DATA_W-1:0] wdata;
   } access_type;

   typedef struct packed {
      logic req;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } mem_type;

   typedef struct packed {
      logic hit_virtual;
      logic hit_low;
      logic hit_high;
      logic [1:0] sel;
      win_kind_type kind;
   } win_hit_type;
endpackage : word_decode_pkg

// [tb/word_decode_props.sv]
`timescale 1ns/1ps
module word_decode_props
   import word_decode_pkg::*;
(
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RSTN,
   // Word and access inputs
   input wire logic [WORD_W-1:0] I_WORD,
   input wire logic I_WORD_VALID,
   input wire logic I_WORD_SKIP,
   input wire logic I_EXT_ENABLE,
   input wire access_type I_ACC,
   input wire logic [DATA_W-1:0] I_MEM_RDATA,
   // Block outputs
   input wire dec_type O_DEC,
   input wire logic [PC_W-1:0] O_PC_TARGET,
   input wire logic O_PC_LOAD,
   input wire mem_type O_MEM,
   input wire logic O_ACC_DONE,
   input wire logic [DATA_W-1:0] O_ACC_RDATA,
   input wire logic O_ACC_BUSY
);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RSTN);
   // Helpers, so that $past sees plain signals
   logic [LIT_W-1:0] lit_now;
   logic [ADDR_W-1:0] acc_addr;
   logic [ADDR_W-1:0] top_addr;
   logic [ADDR_W-1:0] low_addr;
   logic take;
   assign lit_now = I_WORD[LIT_W-1:0];
   assign acc_addr = {I_ACC.bank, I_ACC.file};
   assign top_addr = {HIGH_BANK, I_ACC.file};
   assign low_addr = {LOW_BANK, I_ACC.file};
   assign take = I_ACC.valid && !O_ACC_BUSY;
   // Word steps
   sequence s_first_jump;
      I_WORD_VALID && !I_WORD_SKIP && I_WORD[15:8] == JUMP_OPC;
   endsequence
   sequence s_first_move;
      I_WORD_VALID && !I_WORD_SKIP && I_WORD[15:12] == MOVE_OPC;
   endsequence
   sequence s_second;
      I_WORD_VALID && !I_WORD_SKIP && I_WORD[15:12] == SECOND_MARK;
   endsequence
   sequence s_skip_word;
      I_WORD_VALID && I_WORD_SKIP;
   endsequence
   property p_jump_pair;
      s_first_jump ##1 s_second |=> O_DEC.valid && O_DEC.kind == KIND_JUMP && O_PC_LOAD
         && O_DEC.literal == $past(lit_now);
   endproperty
   a_jump_pair: assert property (p_jump_pair) else $error("jump pair decode wrong");
   property p_move_pair;
      s_first_move ##1 s_second |=> O_DEC.kind == KIND_MOVE && O_DEC.dst == $past(lit_now)
         && O_DEC.src == $past(lit_now, 2);
   endproperty
   a_move_pair: assert property (p_move_pair) else $error("move pair decode wrong");
   property p_first_silent;
      s_first_move |=> !O_DEC.valid;
   endproperty
   a_first_silent: assert property (p_first_silent) else $error("first word answered");
   property p_skip_silent;
      s_skip_word |=> !O_DEC.valid && !O_PC_LOAD;
   endproperty
   a_skip_silent: assert property (p_skip_silent) else $error("skipped word decoded");
   property p_orphan;
      s_skip_word ##1 s_second |=> O_DEC.valid && O_DEC.kind == KIND_NOP && !O_PC_LOAD;
   endproperty
   a_orphan: assert property (p_orphan) else $error("orphan word not a nop");
   property p_pc_load;
      O_PC_LOAD |-> O_DEC.valid && O_PC_TARGET[0] == PC_LSB_VALUE
         && O_PC_TARGET[PC_W-1:9] == O_DEC.literal;
   endproperty
   a_pc_load: assert property (p_pc_load) else $error("jump target malformed");
   property p_mem_read;
      O_MEM.req && !O_MEM.write |-> O_ACC_BUSY ##2 O_ACC_DONE && !O_ACC_BUSY
         && O_ACC_RDATA == $past(I_MEM_RDATA);
   endproperty
   a_mem_read: assert property (p_mem_read) else $error("memory read answer wrong");
   property p_bank_direct;
      take && I_ACC.bank_sel && I_ACC.bank != HIGH_BANK |=> O_MEM.req
         && O_MEM.addr == $past(acc_addr) && O_MEM.write == $past(I_ACC.write);
   endproperty
   a_bank_direct: assert property (p_bank_direct) else $error("banked address wrong");
   property p_ext_high;
      take && I_EXT_ENABLE && !I_ACC.bank_sel && I_ACC.file >= ACCESS_SPLIT
         && I_ACC.file < 8'hD0 |=> O_MEM.req && O_MEM.addr == $past(top_addr);
   endproperty
   a_ext_high: assert property (p_ext_high) else $error("upper access moved");
   property p_low_direct;
      take && !I_EXT_ENABLE && !I_ACC.bank_sel && I_ACC.file < ACCESS_SPLIT
         |=> O_MEM.req && O_MEM.addr == $past(low_addr);
   endproperty
   a_low_direct: assert property (p_low_direct) else $error("lower access moved");
endmodule : word_decode_props

bind word_decode_pointer_unit word_decode_props u_props (.I_CORE_CLK, .I_RSTN, .I_WORD,
   .I_WORD_VALID, .I_WORD_SKIP, .I_EXT_ENABLE, .I_ACC, .I_MEM_RDATA, .O_DEC, .O_PC_TARGET,
   .O_PC_LOAD, .O_MEM, .O_ACC_DONE, .O_ACC_RDATA, .O_ACC_BUSY);

// [tb/data_memory_model.sv]
`timescale 1ns/1ps
module data_memory_model
   import word_decode_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Request from the block
   input wire mem_type i_mem,
   // Read answer
   output logic [DATA_W-1:0] o_rdata
);
   logic [DATA_W-1:0] store [0:4095];
   // Non-zero fill, so a stray read of an unwritten cell cannot pass as 00h
   initial begin
      for (int i = 0; i < 4096; i++) store[i] = 8'hC3;
      o_rdata = 8'h00;
   end
   // Data good only in the cycle after a read; toggles otherwise so stale reads show
   always @(posedge i_clk) begin
      if (i_mem.req && i_mem.write) store[i_mem.addr] <= i_mem.wdata;
      if (i_mem.req && !i_mem.write) o_rdata <= store[i_mem.addr];
      else o_rdata <= ~o_rdata;
   end
endmodule : data_memory_model

// [tb/two_word_decode_indirect_addressing_tb.sv]
`timescale 1ns/1ps
module two_word_decode_indirect_addressing_tb;
   import word_decode_pkg::*;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [WORD_W-1:0] word = 16'h0000;
   logic word_valid = 1'h0;
   logic word_skip = 1'h0;
   logic ext_enable = 1'h0;
   access_type acc = '0;
   logic [DATA_W-1:0] wreg = 8'h00;
   logic [DATA_W-1:0] mem_rdata;
   dec_type dec;
   logic [PC_W-1:0] pc_target;
   logic pc_load;
   mem_type mem;
   logic acc_done;
   logic [DATA_W-1:0] acc_rdata;
   logic acc_busy;
   logic [DATA_W-1:0] rd;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   word_decode_pointer_unit dut (.I_CORE_CLK(clk), .I_RSTN(rst_n), .I_WORD(word),
      .I_WORD_VALID(word_valid), .I_WORD_SKIP(word_skip), .I_EXT_ENABLE(ext_enable),
      .I_ACC(acc), .I_WREG(wreg), .I_MEM_RDATA(mem_rdata), .O_DEC(dec),
      .O_PC_TARGET(pc_target), .O_PC_LOAD(pc_load), .O_MEM(mem), .O_ACC_DONE(acc_done),
      .O_ACC_RDATA(acc_rdata), .O_ACC_BUSY(acc_busy));
   data_memory_model u_mem (.i_clk(clk), .i_mem(mem), .o_rdata(mem_rdata));
   // Clock, 25 ns period
   initial forever #12.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic put(input logic [15:0] w, input logic s);
      @(posedge clk);
      word <= w;
      word_valid <= 1'h1;
      word_skip <= s;
   endtask : put
   // Ends a burst and lets the last decode land
   task automatic stop_words();
      @(posedge clk);
      word_valid <= 1'h0;
      word_skip <= 1'h0;
      #1;
   endtask : stop_words
   // One access; request held one cycle since the block is idle between accesses
   task automatic access(input logic w, input logic bs, input logic [11:0] a,
      input logic [7:0] d);
      int k;
      @(posedge clk);
      acc <= {1'h1, w, bs, a, d};
      @(posedge clk);
      acc.valid <= 1'h0;
      #1;
      for (k = 0; k < 6 && acc_done !== 1'h1; k++) @(posedge clk) #1;
      chk(acc_done, 1'h1);
      rd = acc_rdata;
   endtask : access
   task automatic look(input logic bs, input logic [11:0] a, input logic [7:0] exp);
      access(1'h0, bs, a, 8'h00);
      chk(rd, exp);
   endtask : look
   task automatic t_decode();
      put(16'hEF03, 1'h0);
      put(16'hF000, 1'h0);
      stop_words();
      chk({dec.valid, dec.kind, pc_load}, {1'h1, KIND_JUMP, 1'h1});
      chk(pc_target, 21'h000006);
      put(16'hEC34, 1'h0);
      put(16'hF567, 1'h0);
      stop_words();
      chk(dec.kind, KIND_CALL);
      chk(pc_target, 21'h0ACE68);
      put(16'hC123, 1'h0);
      put(16'hF456, 1'h0);
      stop_words();
      chk({dec.valid, dec.kind, dec.src, dec.dst}, {1'h1, KIND_MOVE, 24'h123456});
      put(16'hC123, 1'h1);
      put(16'hF456, 1'h0);
      stop_words();
      chk({dec.valid, dec.kind, pc_load}, {1'h1, KIND_NOP, 1'h0});
      chk(pc_target, 21'h0ACE68);
      put(16'hF456, 1'h0);
      stop_words();
      chk({dec.valid, dec.kind}, {1'h1, KIND_NOP});
      $display("decode test done");
   endtask : t_decode
   task automatic t_pointer();
      put(16'hEE21, 1'h0);
      put(16'hF0FF, 1'h0);
      stop_words();
      look(1'h1, 12'hFD9, 8'hFF);
      look(1'h1, 12'hFDA, 8'h01);
      access(1'h1, 1'h1, 12'hFDF, 8'h5A);
      look(1'h1, 12'hFDE, 8'h5A);
      look(1'h1, 12'hFD9, 8'h00);
      look(1'h1, 12'hFDA, 8'h02);
      access(1'h1, 1'h1, 12'h200, 8'hA5);
      look(1'h1, 12'hFDD, 8'hA5);
      look(1'h1, 12'hFD9, 8'hFF);
      look(1'h1, 12'hFDA, 8'h01);
      look(1'h1, 12'hFDC, 8'hA5);
      @(posedge clk);
      wreg <= 8'hFF;
      look(1'h1, 12'hFDB, 8'h5A);
      // Point pair two at its own low byte, then write through the decrementing window
      access(1'h1, 1'h1, 12'hFDA, 8'h0F);
      access(1'h1, 1'h1, 12'hFD9, 8'hD9);
      access(1'h1, 1'h1, 12'hFDD, 8'h77);
      look(1'h1, 12'hFD9, 8'h77);
      look(1'h1, 12'hFDA, 8'h0F);
      // Pair two at its own high byte: the stored value must not be stepped
      access(1'h1, 1'h1, 12'hFD9, 8'hDA);
      access(1'h1, 1'h1, 12'hFDD, 8'h0F);
      look(1'h1, 12'hFD9, 8'hDA);
      $display("pointer test done");
   endtask : t_pointer
   task automatic t_window();
      access(1'h1, 1'h1, 12'h010, 8'h99);
      put(16'hEE10, 1'h0);
      put(16'hF010, 1'h0);
      put(16'hEE0F, 1'h0);
      put(16'hF0E7, 1'h0);
      stop_words();
      look(1'h1, 12'hFEF, 8'h00);
      access(1'h1, 1'h1, 12'hFEF, 8'h33);
      look(1'h1, 12'h010, 8'h99);
      look(1'h1, 12'hFE9, 8'hE7);
      $display("window test done");
   endtask : t_window
   task automatic t_ext();
      put(16'hEE21, 1'h0);
      put(16'hF0F0, 1'h0);
      stop_words();
      @(posedge clk);
      ext_enable <= 1'h1;
      look(1'h0, 12'h010, 8'hA5);
      access(1'h1, 1'h0, 12'h05F, 8'h11);
      access(1'h1, 1'h0, 12'h060, 8'h42);
      look(1'h1, 12'h200, 8'hA5);
      look(1'h0, 12'h0EF, 8'h00);
      look(1'h0, 12'h0E7, 8'h99);
      @(posedge clk);
      ext_enable <= 1'h0;
      look(1'h1, 12'h24F, 8'h11);
      look(1'h1, 12'hF60, 8'h42);
      look(1'h0, 12'h010, 8'h99);
      $display("extended test done");
   endtask : t_ext
   // Mid-run reset drops a pending pair and clears the pointers
   task automatic t_reset();
      put(16'hEF03, 1'h0);
      stop_words();
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      chk({pc_load, dec.valid, acc_busy, acc_done}, 4'h0);
      chk(pc_target, 21'h000000);
      put(16'hF000, 1'h0);
      stop_words();
      chk({dec.valid, dec.kind, pc_load}, {1'h1, KIND_NOP, 1'h0});
      look(1'h1, 12'hFE9, 8'h00);
      look(1'h1, 12'hFDA, 8'h00);
      $display("reset test done");
   endtask : t_reset
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   // Hang guard; the run needs only about 150 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_errors++;
         report_and_stop();
      end
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      t_decode();
      t_pointer();
      t_window();
      t_ext();
      t_reset();
      report_and_stop();
   end
endmodule : two_word_decode_indirect_addressing_tb
